// >>> rtl/ebps_top.sv
// External bus pin select: maps bus roles onto shared port pins
// Also holds the reset qualifier and the half-rate wait clock
// Assumes a core bus request port and synchronous pins at 250 MHz
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module ebps_top
   import ebps_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Reset pin, active high
   input  wire logic        rst_pin,
   // Configuration straps
   input  wire logic [7:0]  boot_config_byte_zero,
   input  wire logic        page_mode,
   input  wire logic        ext_code_select_n,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output var  logic [7:0]  reg_rdata,
   // Core bus request
   input  wire logic        bus_req,
   input  wire logic        bus_write,
   input  wire logic        bus_code,
   input  wire logic        bus_code_onchip,
   input  wire logic [23:0] bus_addr,
   input  wire logic [7:0]  bus_wdata,
   output var  logic        bus_done,
   output var  logic [7:0]  bus_rdata,
   output var  logic        fetch_offchip,
   // Port function defaults
   input  wire logic        port1_7_out,
   input  wire logic        port3_7_out,
   input  wire logic        port3_6_out,
   input  wire logic        pca_channel4_io,
   input  wire logic        pca4_use,
   // Memory pins
   output var  logic        addr_latch_strobe,
   output var  logic        program_read_strobe_n,
   output var  logic        pin_p3_6,
   output var  logic        pin_p3_7,
   output var  logic        pin_p1_7,
   output var  logic [7:0]  high_addr_bus_out,
   output var  logic        high_addr_bus_oe_n,
   input  wire logic [7:0]  high_addr_bus_in,
   output var  logic [7:0]  low_addr_data_bus_out,
   output var  logic        low_addr_data_bus_oe_n,
   input  wire logic [7:0]  low_addr_data_bus_in,
   // Wait input on port 1 bit 6
   input  wire logic        wait_in_n
);

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      ebps_state_e st;
      logic [1:0]  region;
      logic        code_ext_only;
      logic        cfg_done;
      logic [7:0]  wctl;
      logic [7:0]  rdata;
      logic        write;
      logic [23:0] addr;
      logic [7:0]  wdata;
      logic        done;
      logic [7:0]  rdbk;
      logic        fetch_off;
      logic        ale;
      logic        program_read_strobe_n_n;
      logic        p36;
      logic        p37;
      logic        p17;
      logic [7:0]  hi_out;
      logic        hi_oe_n;
      logic [7:0]  lo_out;
      logic        lo_oe_n;
   } ebps_top_s;

   ebps_top_s st_r;
   ebps_top_s st_nxt;

   logic rst_ok;
   logic wclk;
   logic any_rst_n;

   ////////////////////////////////////////////////////////////////////////
   // Submodules

   ebps_reset_filter u_rst (
      .clk     (clk),
      .rst_pin (rst_pin),
      .rst_ok  (rst_ok)
   );

   // Either source holds the whole block in reset
   assign any_rst_n = rst_n & ~rst_ok;

   ebps_wait_clock u_wclk (
      .clk    (clk),
      .rst_n  (any_rst_n),
      .enable (st_r.wctl[EBPS_WCLK_EN_BIT]),
      .wclk   (wclk)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next state

   logic        program_read_strobe_n_ok;
   logic        data_rd_ok;
   logic        wr_ok;
   logic        wait_hold;

   always_comb begin
      st_nxt     = st_r;
      program_read_strobe_n_ok    = 1'b0;
      data_rd_ok = 1'b0;
      wr_ok      = 1'b0;
      wait_hold  = 1'b0;
      // Pulses drop unless set below
      st_nxt.ale  = 1'b0;
      st_nxt.done = 1'b0;

      if (!st_r.cfg_done) begin
         st_nxt.region = boot_config_byte_zero[EBPS_REGION_MSB:
                                               EBPS_REGION_LSB];
         st_nxt.code_ext_only = ~ext_code_select_n;
         st_nxt.cfg_done = 1'b1;
      end

      // Register port
      if (reg_wr && reg_addr == EBPS_WAIT_CTRL_ADDR) begin
         // Only the two enable bits are kept
         st_nxt.wctl = EBPS_WAIT_CTRL_RST;
         st_nxt.wctl[EBPS_WCLK_EN_BIT] = reg_wdata[EBPS_WCLK_EN_BIT];
         st_nxt.wctl[EBPS_RTW_EN_BIT]  = reg_wdata[EBPS_RTW_EN_BIT];
      end
      // Unmapped reads return zero
      st_nxt.rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            EBPS_WAIT_CTRL_ADDR: st_nxt.rdata = st_r.wctl;
            EBPS_STATUS_ADDR:    st_nxt.rdata = {3'h0, st_r.code_ext_only,
                                                 st_r.cfg_done, 1'b0,
                                                 st_r.region};
            default:             st_nxt.rdata = 8'h00;
         endcase
      end

      wait_hold = st_r.wctl[EBPS_RTW_EN_BIT] & ~wait_in_n;

      unique case (st_r.region)
         EBPS_RGN_SPLIT: begin
            // Upper half is program space, lower half data space
            program_read_strobe_n_ok    = ~st_r.write & (st_r.addr >= EBPS_CODE_BASE);
            data_rd_ok = ~st_r.write & (st_r.addr <= EBPS_DATA_TOP);
            // Only the legacy data window takes writes
            wr_ok      = st_r.write & (st_r.addr <= EBPS_LEGACY_TOP);
         end
         EBPS_RGN_18BIT, EBPS_RGN_17BIT, EBPS_RGN_16BIT: begin
            // No data read pin: every read uses the program strobe
            program_read_strobe_n_ok    = ~st_r.write;
            data_rd_ok = 1'b0;
            wr_ok      = st_r.write;
         end
      endcase

      // Bus cycle sequencer
      unique case (st_r.st)
         EBPS_IDLE: begin
            // Buses released between cycles
            st_nxt.program_read_strobe_n_n  = 1'b1;
            st_nxt.lo_oe_n = 1'b1;
            st_nxt.hi_oe_n = 1'b1;
            if (bus_req && st_r.cfg_done) begin
               st_nxt.write = bus_write;
               st_nxt.addr  = bus_addr;
               st_nxt.wdata = bus_wdata;
               st_nxt.fetch_off = ~bus_code | st_r.code_ext_only |
                                  ~bus_code_onchip;
               // On-chip fetch ends without a bus cycle
               if (bus_code && !st_r.code_ext_only && bus_code_onchip) begin
                  st_nxt.done = 1'b1;
               end else begin
                  st_nxt.st = EBPS_ADDR;
                  st_nxt.ale = 1'b1;
                  st_nxt.hi_out  = bus_addr[15:8];
                  st_nxt.lo_out  = bus_addr[7:0];
                  st_nxt.hi_oe_n = 1'b0;
                  st_nxt.lo_oe_n = 1'b0;
               end
            end
         end
         EBPS_ADDR: begin
            st_nxt.st = EBPS_DATA;
            // Data phase: page mode moves data to port 2
            if (page_mode) begin
               // page mode data on high bus
               st_nxt.lo_out  = st_r.addr[7:0];
               st_nxt.hi_out  = st_r.wdata;
               st_nxt.hi_oe_n = ~st_r.write;
            end else begin
               st_nxt.hi_out  = st_r.addr[15:8];
               st_nxt.lo_out  = st_r.wdata;
               st_nxt.lo_oe_n = ~st_r.write;
            end
            // Strobes assert with the first data phase
            st_nxt.program_read_strobe_n_n = ~program_read_strobe_n_ok;
         end
         EBPS_DATA: begin
            // Wait input stretches the data phase
            if (!wait_hold) begin
               st_nxt.st     = EBPS_IDLE;
               st_nxt.done   = 1'b1;
               st_nxt.rdbk   = page_mode ? high_addr_bus_in
                                         : low_addr_data_bus_in;
               st_nxt.program_read_strobe_n_n = 1'b1;
               // Release the buses once the cycle is over
               st_nxt.hi_oe_n = 1'b1;
               st_nxt.lo_oe_n = 1'b1;
            end
         end
         default: st_nxt.st = EBPS_IDLE;
      endcase


      // Shared pin muxing
      // Address pins follow the next address: valid with the latch strobe
      st_nxt.p36 = port3_6_out;
      st_nxt.p37 = port3_7_out;
      st_nxt.p17 = st_r.wctl[EBPS_WCLK_EN_BIT] ? wclk :
                   (pca4_use ? pca_channel4_io : port1_7_out);
      unique case (st_r.region)
         EBPS_RGN_18BIT: begin
            st_nxt.p17 = st_nxt.addr[17];
            st_nxt.p37 = st_nxt.addr[16];
         end
         EBPS_RGN_17BIT: begin
            // bit 16 only
            // Pin 1.7 keeps its port, PCA or wait clock use
            st_nxt.p37 = st_nxt.addr[16];
         end
         EBPS_RGN_16BIT: begin
            // port 3 bit 7 free
            // Pin 1.7 keeps its port, PCA or wait clock use
            st_nxt.p37 = port3_7_out;
         end
         EBPS_RGN_SPLIT: begin
            // Data read strobe on port 3 bit 7
            st_nxt.p37 = ~(data_rd_ok && st_nxt.st == EBPS_DATA);
         end
      endcase

      // Strobes stand while the next state is a data phase,
      // so wait states hold them steady for the memory
      if (st_nxt.st == EBPS_DATA && st_r.write) begin
         st_nxt.p36 = ~wr_ok;
      end else if (st_r.st != EBPS_IDLE) begin
         st_nxt.p36 = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk) begin
      if (!any_rst_n) begin
         st_r <= '{
            st:            EBPS_IDLE,
            region:        EBPS_RGN_18BIT,
            code_ext_only: 1'b0,
            cfg_done:      1'b0,
            wctl:          EBPS_WAIT_CTRL_RST,
            rdata:         8'h00,
            write:         1'b0,
            addr:          24'h000000,
            wdata:         8'h00,
            done:          1'b0,
            rdbk:          8'h00,
            fetch_off:     1'b0,
            ale:           1'b0,
            program_read_strobe_n_n:        1'b1,
            p36:           1'b1,
            p37:           1'b1,
            p17:           1'b1,
            hi_out:        8'hFF,
            hi_oe_n:       1'b1,
            lo_out:        8'hFF,
            lo_oe_n:       1'b1
         };
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign reg_rdata              = st_r.rdata;
   assign bus_done               = st_r.done;
   assign bus_rdata              = st_r.rdbk;
   assign fetch_offchip          = st_r.fetch_off;
   assign addr_latch_strobe      = st_r.ale;
   assign program_read_strobe_n  = st_r.program_read_strobe_n_n;
   assign pin_p3_6               = st_r.p36;
   assign pin_p3_7               = st_r.p37;
   assign pin_p1_7               = st_r.p17;
   assign high_addr_bus_out      = st_r.hi_out;
   assign high_addr_bus_oe_n     = st_r.hi_oe_n;
   assign low_addr_data_bus_out  = st_r.lo_out;
   assign low_addr_data_bus_oe_n = st_r.lo_oe_n;

endmodule : ebps_top

`default_nettype wire

// >>> rtl/ebps_pkg.sv
// Constants for the external bus pin select block
// Assumes a single 250 MHz clock and a plain register port
package ebps_pkg;

   // Register map
   localparam logic [7:0] EBPS_WAIT_CTRL_ADDR  = 8'hA7;
   localparam logic [7:0] EBPS_STATUS_ADDR     = 8'hA8;
   localparam logic [7:0] EBPS_WAIT_CTRL_RST   = 8'h00;

   // Wait-state control fields
   localparam int EBPS_RTW_EN_BIT   = 0;
   localparam int EBPS_WCLK_EN_BIT  = 1;

   // Configuration byte field position
   localparam int EBPS_REGION_LSB   = 2;
   localparam int EBPS_REGION_MSB   = 3;

   // Region select encodings
   localparam logic [1:0] EBPS_RGN_18BIT  = 2'h0;
   localparam logic [1:0] EBPS_RGN_17BIT  = 2'h1;
   localparam logic [1:0] EBPS_RGN_16BIT  = 2'h2;
   localparam logic [1:0] EBPS_RGN_SPLIT  = 2'h3;

   // Address split point for split region mode
   localparam logic [23:0] EBPS_DATA_TOP  = 24'h7FFFFF;
   localparam logic [23:0] EBPS_CODE_BASE = 24'h800000;

   // Legacy data window: writes below 64 Kbyte in split mode
   localparam logic [23:0] EBPS_LEGACY_TOP = 24'h00FFFF;

   // Reset filter: 64 oscillator periods at 4 ns
   localparam int EBPS_RST_PERIODS = 64;
   localparam int EBPS_CLK_NS      = 4;
   localparam int EBPS_RST_NS      = EBPS_RST_PERIODS * EBPS_CLK_NS;
   localparam int EBPS_RST_CYCLES  = EBPS_RST_NS / EBPS_CLK_NS;
   localparam logic [6:0] EBPS_RST_CNT_MAX = 7'(EBPS_RST_CYCLES - 1);

   // Bus cycle phase lengths
   localparam logic [1:0] EBPS_ALE_CYCLES  = 2'h1;

   // Bus cycle states
   typedef enum logic [1:0] {
      EBPS_IDLE,
      EBPS_ADDR,
      EBPS_DATA
   } ebps_state_e;

endpackage : ebps_pkg

// >>> rtl/ebps_reset_filter.sv
// Reset qualifier: internal reset after reset pin held long enough
// Assumes the reset pin is synchronous to clk
`timescale 1ns/100ps
`default_nettype none

module ebps_reset_filter
   import ebps_pkg::*;
(
   // Clock and pin
   input  wire logic clk,
   input  wire logic rst_pin,
   // Qualified reset
   output var  logic rst_ok
);

   typedef struct packed {
      logic [6:0] cnt;
      logic       ok;
   } ebps_rf_s;

   ebps_rf_s st_r;
   ebps_rf_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (!rst_pin) begin
         st_nxt.cnt = 7'h00;
         st_nxt.ok  = 1'b0;
      end else if (st_r.cnt == EBPS_RST_CNT_MAX) begin
         st_nxt.ok  = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + 7'h01;
      end
   end

   always_ff @(posedge clk) begin
      st_r <= st_nxt;
   end

   assign rst_ok = st_r.ok;

endmodule : ebps_reset_filter

`default_nettype wire

// >>> rtl/ebps_wait_clock.sv
// Half-rate square wave generator for the wait clock
// Assumes a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none

module ebps_wait_clock (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Control
   input  wire logic enable,
   // Square wave
   output var  logic wclk
);

   typedef struct packed {
      logic ph;
   } ebps_wc_s;

   ebps_wc_s st_r;
   ebps_wc_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (enable) begin
         st_nxt.ph = ~st_r.ph;
      end else begin
         st_nxt.ph = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign wclk = st_r.ph;

endmodule : ebps_wait_clock

`default_nettype wire

// >>> tb/ebps_monitor.sv
// Checker for the external bus pin select top module
// Assumes a bind onto ebps_top and one clock with a sync reset
`timescale 1ns/100ps
`default_nettype none
module ebps_monitor
   import ebps_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // Register port
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   // Bus request and pins
   input wire logic        bus_req,
   input wire logic [23:0] bus_addr,
   input wire logic        bus_done,
   input wire logic        addr_latch_strobe,
   input wire logic        program_read_strobe_n,
   input wire logic        pin_p3_6,
   input wire logic [7:0]  high_addr_bus_out,
   input wire logic        high_addr_bus_oe_n,
   input wire logic [7:0]  low_addr_data_bus_out
);
   default clocking mck @(posedge clk); endclocking
   default disable iff (!rst_n);

   ale_pulse_a: assert property (
      addr_latch_strobe |=> !addr_latch_strobe)
      else $error("latch strobe longer than one cycle");
   ale_high_addr_a: assert property (
      addr_latch_strobe |-> !high_addr_bus_oe_n &&
      high_addr_bus_out == bus_addr[15:8])
      else $error("high address missing at latch strobe");
   ale_low_addr_a: assert property (
      addr_latch_strobe |-> low_addr_data_bus_out == bus_addr[7:0])
      else $error("low address missing at latch strobe");
   read_after_ale_a: assert property (
      $fell(program_read_strobe_n) |-> $past(addr_latch_strobe))
      else $error("read strobe without address phase");
   write_after_ale_a: assert property (
      $fell(pin_p3_6) |-> $past(addr_latch_strobe))
      else $error("write strobe without address phase");
   strobe_end_done_a: assert property (
      $rose(program_read_strobe_n) |-> bus_done)
      else $error("read strobe ended without done");
   req_done_a: assert property (
      bus_req |-> ##[1:30] bus_done)
      else $error("bus cycle never finished");
   done_pulse_a: assert property (
      bus_done |=> !bus_done)
      else $error("done longer than one cycle");
   unmapped_zero_a: assert property (
      reg_rd && reg_addr != EBPS_WAIT_CTRL_ADDR &&
      reg_addr != EBPS_STATUS_ADDR |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   wait_reg_a: assert property (
      reg_wr && reg_addr == EBPS_WAIT_CTRL_ADDR ##1
      reg_rd && reg_addr == EBPS_WAIT_CTRL_ADDR
      |=> reg_rdata == ($past(reg_wdata, 2) & 8'h03))
      else $error("wait control readback wrong");
endmodule // ebps_monitor

bind ebps_top ebps_monitor u_ebps_monitor (.clk, .rst_n, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bus_req, .bus_addr,
   .bus_done, .addr_latch_strobe, .program_read_strobe_n, .pin_p3_6,
   .high_addr_bus_out, .high_addr_bus_oe_n, .low_addr_data_bus_out);
`default_nettype wire

// >>> tb/ebps_mem_model.sv
// External memory with address latch facing the pin select block
// Assumes the bench resolves bus wires from the design's enables
`timescale 1ns/100ps
`default_nettype none
module ebps_mem_model (
   // Clock and mode
   input  wire logic       clk,
   input  wire logic       page_mode,
   input  wire logic       split,
   input  wire logic [3:0] slow,
   // Strobes and wires
   input  wire logic       ale,
   input  wire logic       program_read_strobe_n_n,
   input  wire logic       rd_n,
   input  wire logic       wr_n,
   input  wire logic [7:0] hi_wire,
   input  wire logic [7:0] lo_wire,
   // Driven back
   output logic [7:0]      mem_hi,
   output logic [7:0]      mem_lo,
   output logic            wait_n
);
   logic [7:0] a_lo, a_hi, dat;
   logic [7:0] junk = 8'hA5;
   logic [3:0] cnt = 4'h0;
   logic       rd_act, act;
   assign rd_act = !program_read_strobe_n_n || (split && !rd_n);
   assign act = rd_act || !wr_n;
   assign dat = a_lo ^ a_hi ^ 8'h3C;
   always_ff @(posedge clk) begin
      junk <= ~junk;
      cnt <= act ? cnt + 4'h1 : 4'h0;
      if (ale) begin
         a_lo <= lo_wire;
         a_hi <= hi_wire;
      end
   end
   // Released bus shows a changing pattern
   assign mem_hi = (rd_act && page_mode) ? dat : junk;
   assign mem_lo = (rd_act && !page_mode) ? dat : junk;
   assign wait_n = !(act && cnt < slow);
endmodule // ebps_mem_model
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the external bus pin select block
// Assumes the memory model and the checker bind are compiled
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import ebps_pkg::*;
   ;
   logic clk = 1'b0, rst_n = 1'b0, rst_pin = 1'b0, page_mode = 1'b0;
   logic ext_code_select_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic bus_req = 1'b0, bus_write = 1'b0, bus_code = 1'b0;
   logic bus_code_onchip = 1'b0, port1_7_out = 1'b1, port3_7_out = 1'b0;
   logic port3_6_out = 1'b1, pca_channel4_io = 1'b0, pca4_use = 1'b0;
   logic [7:0] boot_config_byte_zero = 8'h00, reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00, bus_wdata = 8'h00;
   logic [23:0] bus_addr = 24'h000000;
   logic [7:0] reg_rdata, bus_rdata, high_addr_bus_out, mem_hi, mem_lo;
   logic [7:0] low_addr_data_bus_out, high_addr_bus_in, low_addr_data_bus_in;
   logic bus_done, fetch_offchip, addr_latch_strobe, program_read_strobe_n;
   logic pin_p3_6, pin_p3_7, pin_p1_7, high_addr_bus_oe_n, wait_in_n;
   logic low_addr_data_bus_oe_n, p, wclk_on = 1'b0;
   logic [1:0] rgn = 2'h0;
   logic [3:0] slow = 4'h0;
   int error_cnt = 0, total_checks = 0;
   logic [7:0] cfgs [4] = '{8'hF3, 8'hF7, 8'h0B, 8'h0C};
   logic [23:0] adrs [4] = '{24'h03A55A, 24'h800001, 24'h00FFFF, 24'h010000};

   assign high_addr_bus_in = high_addr_bus_oe_n ? mem_hi : high_addr_bus_out;
   assign low_addr_data_bus_in =
      low_addr_data_bus_oe_n ? mem_lo : low_addr_data_bus_out;

   ebps_top u_ebps_top (.clk, .rst_n, .rst_pin, .boot_config_byte_zero,
      .page_mode, .ext_code_select_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .bus_req, .bus_write, .bus_code,
      .bus_code_onchip, .bus_addr, .bus_wdata, .bus_done, .bus_rdata,
      .fetch_offchip, .port1_7_out, .port3_7_out, .port3_6_out,
      .pca_channel4_io, .pca4_use, .addr_latch_strobe,
      .program_read_strobe_n, .pin_p3_6, .pin_p3_7, .pin_p1_7,
      .high_addr_bus_out, .high_addr_bus_oe_n, .high_addr_bus_in,
      .low_addr_data_bus_out, .low_addr_data_bus_oe_n,
      .low_addr_data_bus_in, .wait_in_n);
   ebps_mem_model u_mem (.clk, .page_mode, .split(rgn == 2'h3), .slow,
      .ale(addr_latch_strobe), .program_read_strobe_n_n(program_read_strobe_n),
      .rd_n(pin_p3_7), .wr_n(pin_p3_6), .hi_wire(high_addr_bus_in),
      .lo_wire(low_addr_data_bus_in), .mem_hi, .mem_lo, .wait_n(wait_in_n));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #2 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [23:0] s, e);
      total_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic complete_run();
      if (error_cnt == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic rst(input logic [7:0] cfg, input logic ea);
      rst_n <= 1'b0;
      boot_config_byte_zero <= cfg;
      ext_code_select_n <= ea;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, e);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", reg_rdata, e);
      @(posedge clk);
   endtask

   task automatic bop(input logic code, w, input logic [23:0] a, int ws);
      logic ext, sp;
      int n;
      ext = !(code && ext_code_select_n);
      sp = (rgn == 2'h3);
      bus_req <= 1'b1;
      bus_write <= w;
      bus_code <= code;
      bus_code_onchip <= code;
      bus_addr <= a;
      bus_wdata <= a[7:0] ^ 8'h96;
      @(posedge clk);
      bus_req <= 1'b0;
      #1;
      n = 0;
      if (ext) begin
         chk("ale", addr_latch_strobe, 1'b1);
         chk("high_addr", high_addr_bus_out, a[15:8]);
         chk("low_addr", low_addr_data_bus_out, a[7:0]);
         if (rgn == 2'h0)
            chk("a17", pin_p1_7, a[17]);
         else if (!wclk_on)
            chk("p1_7", pin_p1_7, pca4_use ? pca_channel4_io : port1_7_out);
         if (rgn < 2'h2)
            chk("a16", pin_p3_7, a[16]);
         else if (rgn == 2'h2)
            chk("p3_7", pin_p3_7, port3_7_out);
         @(posedge clk);
         #1;
         chk("program_read_strobe_n", program_read_strobe_n,
             !(!w && (!sp || a >= 24'h800000)));
         if (sp)
            chk("rd", pin_p3_7, !(!w && a <= 24'h7FFFFF));
         chk("wr", pin_p3_6, !(w && (!sp || a <= 24'h00FFFF)));
         if (w)
            chk("wdata", page_mode ? high_addr_bus_out :
                low_addr_data_bus_out, a[7:0] ^ 8'h96);
      end
      while (bus_done !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (ws == 0)
         chk("latency", n, ext);
      else
         chk("stretch", n > ws, 1'b1);
      if (ext && !w)
         chk("rdata", bus_rdata, a[7:0] ^ a[15:8] ^ 8'h3C);
      if (code)
         chk("offchip", fetch_offchip, ext);
      @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      for (int r = 0; r < 4; r++) begin
         rgn = r[1:0];
         page_mode <= r[0];
         pca4_use <= r[0];
         port3_7_out <= r[1];
         rst(cfgs[r], r[1]);
         rd(EBPS_STATUS_ADDR, {3'h0, !r[1], 2'h2, rgn});
         wclk_on = (r == 0);
         if (r == 0)
            wr(EBPS_WAIT_CTRL_ADDR, 8'h02);
         foreach (adrs[i]) begin
            bop(1'b0, 1'b0, adrs[i], 0);
            bop(1'b0, 1'b1, adrs[i], 0);
         end
         bop(1'b1, 1'b0, 24'h001234, 0);
      end
      wr(EBPS_WAIT_CTRL_ADDR, 8'hFF);
      rd(EBPS_WAIT_CTRL_ADDR, 8'h03);
      wr(8'h55, 8'hFF);
      rd(8'h55, 8'h00);
      wclk_on = 1'b1;
      wr(EBPS_WAIT_CTRL_ADDR, 8'h02);
      repeat (3) @(posedge clk);
      #1;
      p = pin_p1_7;
      repeat (4) begin
         @(posedge clk);
         #1;
         chk("wclk", pin_p1_7, !p);
         p = pin_p1_7;
      end
      @(posedge clk);
      wr(EBPS_WAIT_CTRL_ADDR, 8'h01);
      slow = 4'h3;
      bop(1'b0, 1'b0, 24'h001234, 3);
      wr(EBPS_WAIT_CTRL_ADDR, 8'h00);
      bop(1'b0, 1'b0, 24'h001234, 0);
      slow = 4'h0;
      wr(EBPS_WAIT_CTRL_ADDR, 8'h03);
      rst_pin <= 1'b1;
      repeat (70) @(posedge clk);
      rst_pin <= 1'b0;
      repeat (2) @(posedge clk);
      rd(EBPS_WAIT_CTRL_ADDR, 8'h00);
      complete_run();
   end

   // Cuts a hang short
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
